// ---- src/dbg_defines.vh ----
// constants shared by the debug command decoder and its helpers
`ifndef DBG_DEFINES_VH
`define DBG_DEFINES_VH

// ==========================================================================
// command codes, non-intrusive group
// ==========================================================================
`define DBG_CMD_ACK_ON       8'hD5
`define DBG_CMD_ACK_OFF      8'hD6
`define DBG_CMD_HALT         8'h90
`define DBG_CMD_STAT_FETCH   8'hE4
`define DBG_CMD_CTRL_LOAD    8'hC4
`define DBG_CMD_MEM_FETCH    8'hE0
`define DBG_CMD_MEM_FETCH_S  8'hE1
`define DBG_CMD_MEM_REFETCH  8'hE8
`define DBG_CMD_MEM_STORE    8'hC0
`define DBG_CMD_MEM_STORE_S  8'hC1
`define DBG_CMD_BRK_FETCH    8'hE2
`define DBG_CMD_BRK_LOAD     8'hC2

// ==========================================================================
// command codes, active background group
// ==========================================================================
`define DBG_CMD_RESUME       8'h08
`define DBG_CMD_STEP         8'h10
`define DBG_CMD_RESUME_TAG   8'h18
`define DBG_CMD_ACC_FETCH    8'h68
`define DBG_CMD_FLG_FETCH    8'h69
`define DBG_CMD_PC_FETCH     8'h6B
`define DBG_CMD_IDX_FETCH    8'h6C
`define DBG_CMD_SP_FETCH     8'h6F
`define DBG_CMD_NXT_FETCH    8'h70
`define DBG_CMD_NXT_FETCH_S  8'h71
`define DBG_CMD_ACC_LOAD     8'h48
`define DBG_CMD_FLG_LOAD     8'h49
`define DBG_CMD_PC_LOAD      8'h4B
`define DBG_CMD_IDX_LOAD     8'h4C
`define DBG_CMD_SP_LOAD      8'h4F
`define DBG_CMD_NXT_STORE    8'h50
`define DBG_CMD_NXT_STORE_S  8'h51

// ==========================================================================
// status and control byte layout
// ==========================================================================
`define DBG_SC_ALLOW_BIT     7
`define DBG_SC_BGND_BIT      6
`define DBG_SC_BRK_EN_BIT    5
`define DBG_SC_ACK_BIT       4
`define DBG_SC_WR_MASK       8'hA0
`define DBG_SC_RESET         8'h00

// ==========================================================================
// cpu register select codes
// ==========================================================================
`define DBG_SEL_ACC          3'h0
`define DBG_SEL_FLG          3'h1
`define DBG_SEL_PC           3'h2
`define DBG_SEL_IDX          3'h3
`define DBG_SEL_SP           3'h4

// ==========================================================================
// timing counts in bus clock cycles
// ==========================================================================
`define DBG_DELAY_CYCLES     8'h10
`define DBG_SYNC_CYCLES      8'h80

`endif

// ---- src/dbg_delay_timer.v ----
// fixed-length delay timer between host request and device answer
`timescale 1ns/1ns
`include "dbg_defines.vh"

module dbg_delay_timer (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       ce_in,
	input  wire       start_in,
	output reg        done_out
);

	// ======================================================================
	// down counter
	// ======================================================================
	reg  [7:0] count;   // cycles still to wait
	reg        run;     // timer active

	// start reloads, done pulses once when the count runs out
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count    <= 8'h00;
			run      <= 1'b0;
			done_out <= 1'b0;
		end else if (ce_in) begin
			done_out <= 1'b0;
			if (start_in) begin
				count <= `DBG_DELAY_CYCLES - 8'h01;
				run   <= 1'b1;
			end else if (run) begin
				if (count == 8'h00) begin
					run      <= 1'b0;
					done_out <= 1'b1;
				end else begin
					count <= count - 8'h01;
				end
			end
		end
	end

endmodule

// ---- src/dbg_sync_pulse.v ----
// timed reference pulse generator answering a speed reference request
`timescale 1ns/1ns
`include "dbg_defines.vh"

module dbg_sync_pulse (
	input  wire       clk_in,
	input  wire       rst_in,
	input  wire       ce_in,
	input  wire       req_in,
	output reg        pulse_out
);

	// ======================================================================
	// pulse width counter
	// ======================================================================
	reg  [7:0] count;   // remaining pulse cycles

	// a request during a pulse restarts it, so the pulse ends 128 cycles after the last request
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count     <= 8'h00;
			pulse_out <= 1'b0;
		end else if (ce_in) begin
			if (req_in) begin
				count     <= `DBG_SYNC_CYCLES - 8'h01;
				pulse_out <= 1'b1;
			end else if (count != 8'h00) begin
				count <= count - 8'h01;
			end else begin
				pulse_out <= 1'b0;
			end
		end
	end

endmodule

// ---- src/dbg_cmd_decoder.v ----
// background debug command decoder: byte stream in, memory and cpu access out
`timescale 1ns/1ns
`include "dbg_defines.vh"

// Contract
// - speed reference request answered with timed pulse
// - D5 enables, D6 disables acknowledge
// - 90 halts only if entry allowed
// - E4 returns status, C4 writes control
// - E0 returns memory byte after delay
// - E1 returns status then memory byte
// - E8 rereads last address with status
// - C0 stores byte at address, then delay
// - C1 stores byte, then returns status
// - E2 reads, C2 loads breakpoint register
// - 08 resumes user program from counter
// - 10 steps one instruction, rehalts
// - 18 acts as plain resume
// - 68 and 69 return accumulator, flags
// - 6B 6C 6F return 16-bit registers
// - 48 and 49 load accumulator, flags
// - 4B 4C 4F load 16-bit registers
// - 70 increments index, returns memory byte
// - 71 increments index, returns status, byte
// - 50/51 increment index, store byte
module dbg_cmd_decoder (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        ce_in,
	input  wire        sync_req_in,
	input  wire        rx_valid_in,
	input  wire [7:0]  rx_byte_in,
	output reg         tx_valid_out,
	output reg  [7:0]  tx_byte_out,
	output reg         sync_pulse_out,
	output reg         ack_pulse_out,
	output reg         busy_out,
	output reg  [15:0] mem_addr_out,
	output reg  [7:0]  mem_wdata_out,
	output reg         mem_rd_out,
	output reg         mem_wr_out,
	input  wire [7:0]  mem_rdata_in,
	input  wire [7:0]  cpu_acc_in,
	input  wire [7:0]  cpu_flags_in,
	input  wire [15:0] cpu_pc_in,
	input  wire [15:0] cpu_idx_in,
	input  wire [15:0] cpu_sp_in,
	input  wire        cpu_step_done_in,
	output reg         cpu_wr_out,
	output reg  [2:0]  cpu_wr_sel_out,
	output reg  [15:0] cpu_wr_data_out,
	output reg         cpu_resume_out,
	output reg         cpu_step_out,
	output reg         cpu_halt_out,
	output reg  [15:0] brk_addr_out,
	output reg         brk_en_out
);

	// ======================================================================
	// state codes
	// ======================================================================
	localparam [2:0] ST_IDLE = 3'h0;  // waiting for a command byte
	localparam [2:0] ST_RECV = 3'h1;  // collecting address and data bytes
	localparam [2:0] ST_EXEC = 3'h2;  // carrying out the command
	localparam [2:0] ST_CAPT = 3'h3;  // taking memory read data
	localparam [2:0] ST_WAIT = 3'h4;  // answer delay running
	localparam [2:0] ST_SEND = 3'h5;  // returning answer bytes

	// ======================================================================
	// decode functions
	// ======================================================================
	// bytes the host sends after the command byte
	function [1:0] dbg_in_len;
		input [7:0] c;
		begin
			case (c)
				`DBG_CMD_CTRL_LOAD,
				`DBG_CMD_ACC_LOAD,
				`DBG_CMD_FLG_LOAD,
				`DBG_CMD_NXT_STORE,
				`DBG_CMD_NXT_STORE_S:  dbg_in_len = 2'h1;
				`DBG_CMD_MEM_FETCH,
				`DBG_CMD_MEM_FETCH_S,
				`DBG_CMD_BRK_LOAD,
				`DBG_CMD_PC_LOAD,
				`DBG_CMD_IDX_LOAD,
				`DBG_CMD_SP_LOAD:      dbg_in_len = 2'h2;
				`DBG_CMD_MEM_STORE,
				`DBG_CMD_MEM_STORE_S:  dbg_in_len = 2'h3;
				default:               dbg_in_len = 2'h0;
			endcase
		end
	endfunction

	// commands whose coding carries no delay
	function dbg_no_delay;
		input [7:0] c;
		begin
			case (c)
				`DBG_CMD_STAT_FETCH,
				`DBG_CMD_CTRL_LOAD,
				`DBG_CMD_MEM_REFETCH,
				`DBG_CMD_BRK_FETCH,
				`DBG_CMD_BRK_LOAD:     dbg_no_delay = 1'b1;
				default:               dbg_no_delay = 1'b0;
			endcase
		end
	endfunction

	// commands that fetch a memory byte
	function dbg_mem_fetch;
		input [7:0] c;
		begin
			case (c)
				`DBG_CMD_MEM_FETCH,
				`DBG_CMD_MEM_FETCH_S,
				`DBG_CMD_MEM_REFETCH,
				`DBG_CMD_NXT_FETCH,
				`DBG_CMD_NXT_FETCH_S:  dbg_mem_fetch = 1'b1;
				default:               dbg_mem_fetch = 1'b0;
			endcase
		end
	endfunction

	// commands that put a status byte ahead of any data
	function dbg_with_state;
		input [7:0] c;
		begin
			case (c)
				`DBG_CMD_MEM_FETCH_S,
				`DBG_CMD_MEM_REFETCH,
				`DBG_CMD_NXT_FETCH_S,
				`DBG_CMD_MEM_STORE_S,
				`DBG_CMD_NXT_STORE_S:  dbg_with_state = 1'b1;
				default:               dbg_with_state = 1'b0;
			endcase
		end
	endfunction

	// ======================================================================
	// working registers
	// ======================================================================
	reg  [2:0]  state;       // sequencer state
	reg  [7:0]  cmd;         // command byte being served
	reg  [1:0]  need;        // bytes still to collect
	reg  [23:0] shreg;       // collected bytes, last one lowest
	reg         void_cmd;    // command consumed but not carried out
	reg  [23:0] rep;         // answer bytes, next one highest
	reg  [1:0]  rep_n;       // answer bytes left
	reg  [15:0] last_addr;   // address of most recent memory fetch
	reg  [7:0]  ctrl;        // writable control bits
	reg         ack_en;      // acknowledge handshake switched on
	reg         bgnd;        // processor held in background state
	reg         dly_start;   // kicks the answer delay
	wire        dly_done;    // answer delay elapsed
	wire        sync_pulse;  // reference pulse from generator
	wire [7:0]  status;      // status byte as seen by the host
	wire [15:0] idx_next;    // index pair plus one

	assign status   = {ctrl[`DBG_SC_ALLOW_BIT], bgnd, ctrl[`DBG_SC_BRK_EN_BIT],
		ack_en, 4'h0};
	assign idx_next = cpu_idx_in + 16'h0001;

	// ======================================================================
	// helpers
	// ======================================================================
	dbg_delay_timer u_delay (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.ce_in    (ce_in),
		.start_in (dly_start),
		.done_out (dly_done)
	);

	dbg_sync_pulse u_sync (
		.clk_in    (clk_in),
		.rst_in    (rst_in),
		.ce_in     (ce_in),
		.req_in    (sync_req_in),
		.pulse_out (sync_pulse)
	);

	// ======================================================================
	// command sequencer
	// ======================================================================
	// strobes default low each cycle; a sync request aborts any command
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state           <= ST_IDLE;
			cmd             <= 8'h00;
			need            <= 2'h0;
			shreg           <= 24'h000000;
			void_cmd        <= 1'b0;
			rep             <= 24'h000000;
			rep_n           <= 2'h0;
			last_addr       <= 16'h0000;
			ctrl            <= `DBG_SC_RESET;
			ack_en          <= 1'b0;
			bgnd            <= 1'b0;
			dly_start       <= 1'b0;
			tx_valid_out    <= 1'b0;
			tx_byte_out     <= 8'h00;
			sync_pulse_out  <= 1'b0;
			ack_pulse_out   <= 1'b0;
			busy_out        <= 1'b0;
			mem_addr_out    <= 16'h0000;
			mem_wdata_out   <= 8'h00;
			mem_rd_out      <= 1'b0;
			mem_wr_out      <= 1'b0;
			cpu_wr_out      <= 1'b0;
			cpu_wr_sel_out  <= 3'h0;
			cpu_wr_data_out <= 16'h0000;
			cpu_resume_out  <= 1'b0;
			cpu_step_out    <= 1'b0;
			cpu_halt_out    <= 1'b0;
			brk_addr_out    <= 16'h0000;
			brk_en_out      <= 1'b0;
		end else if (ce_in) begin
			dly_start      <= 1'b0;
			tx_valid_out   <= 1'b0;
			ack_pulse_out  <= 1'b0;
			mem_rd_out     <= 1'b0;
			mem_wr_out     <= 1'b0;
			cpu_wr_out     <= 1'b0;
			cpu_resume_out <= 1'b0;
			cpu_step_out   <= 1'b0;
			sync_pulse_out <= sync_pulse;
			cpu_halt_out   <= bgnd;
			brk_en_out     <= ctrl[`DBG_SC_BRK_EN_BIT];
			busy_out       <= (state != ST_IDLE);
			if (sync_req_in) begin
				state <= ST_IDLE;
				rep_n <= 2'h0;
			end else begin
				case (state)
					ST_IDLE: begin
						if (rx_valid_in) begin
							cmd      <= rx_byte_in;
							need     <= dbg_in_len(rx_byte_in);
							// halt-only group has bit 7 clear
							void_cmd <= ~rx_byte_in[7] & ~bgnd;
							state    <= (dbg_in_len(rx_byte_in) == 2'h0) ?
								ST_EXEC : ST_RECV;
						end
					end
					ST_RECV: begin
						if (rx_valid_in) begin
							shreg <= {shreg[15:0], rx_byte_in};
							need  <= need - 2'h1;
							if (need == 2'h1)
								state <= ST_EXEC;
						end
					end
					ST_EXEC: begin
						rep   <= 24'h000000;
						rep_n <= 2'h0;
						state <= ST_WAIT;
						dly_start <= ~dbg_no_delay(cmd);
						if (void_cmd) begin
							state     <= ST_IDLE;
							dly_start <= 1'b0;
						end else begin
							if (dbg_with_state(cmd)) begin
								rep   <= {status, 16'h0000};
								rep_n <= 2'h1;
							end
							if (dbg_mem_fetch(cmd)) begin
								mem_rd_out <= 1'b1;
								state      <= ST_CAPT;
								dly_start  <= 1'b0;
							end
							case (cmd)
								`DBG_CMD_ACK_ON:  ack_en <= 1'b1;
								`DBG_CMD_ACK_OFF: ack_en <= 1'b0;
								`DBG_CMD_HALT: begin
									if (ctrl[`DBG_SC_ALLOW_BIT])
										bgnd <= 1'b1;
								end
								`DBG_CMD_STAT_FETCH: begin
									rep   <= {status, 16'h0000};
									rep_n <= 2'h1;
								end
								`DBG_CMD_CTRL_LOAD:
									ctrl <= shreg[7:0] & `DBG_SC_WR_MASK;
								`DBG_CMD_MEM_FETCH,
								`DBG_CMD_MEM_FETCH_S: begin
									mem_addr_out <= shreg[15:0];
									last_addr    <= shreg[15:0];
								end
								`DBG_CMD_MEM_REFETCH:
									mem_addr_out <= last_addr;
								`DBG_CMD_MEM_STORE,
								`DBG_CMD_MEM_STORE_S: begin
									mem_addr_out  <= shreg[23:8];
									mem_wdata_out <= shreg[7:0];
									mem_wr_out    <= 1'b1;
								end
								`DBG_CMD_BRK_FETCH: begin
									rep   <= {brk_addr_out, 8'h00};
									rep_n <= 2'h2;
								end
								`DBG_CMD_BRK_LOAD:
									brk_addr_out <= shreg[15:0];
								`DBG_CMD_RESUME,
								`DBG_CMD_RESUME_TAG:
									bgnd <= 1'b0;
								`DBG_CMD_STEP:
									bgnd <= 1'b0;
								`DBG_CMD_ACC_FETCH: begin
									rep   <= {cpu_acc_in, 16'h0000};
									rep_n <= 2'h1;
								end
								`DBG_CMD_FLG_FETCH: begin
									rep   <= {cpu_flags_in, 16'h0000};
									rep_n <= 2'h1;
								end
								`DBG_CMD_PC_FETCH: begin
									rep   <= {cpu_pc_in, 8'h00};
									rep_n <= 2'h2;
								end
								`DBG_CMD_IDX_FETCH: begin
									rep   <= {cpu_idx_in, 8'h00};
									rep_n <= 2'h2;
								end
								`DBG_CMD_SP_FETCH: begin
									rep   <= {cpu_sp_in, 8'h00};
									rep_n <= 2'h2;
								end
								`DBG_CMD_ACC_LOAD,
								`DBG_CMD_FLG_LOAD: begin
									cpu_wr_out      <= 1'b1;
									cpu_wr_sel_out  <= cmd[0] ? `DBG_SEL_FLG : `DBG_SEL_ACC;
									cpu_wr_data_out <= {8'h00, shreg[7:0]};
								end
								`DBG_CMD_PC_LOAD,
								`DBG_CMD_IDX_LOAD,
								`DBG_CMD_SP_LOAD: begin
									cpu_wr_out      <= 1'b1;
									cpu_wr_sel_out  <= (cmd == `DBG_CMD_PC_LOAD) ? `DBG_SEL_PC :
										(cmd == `DBG_CMD_IDX_LOAD) ? `DBG_SEL_IDX : `DBG_SEL_SP;
									cpu_wr_data_out <= shreg[15:0];
								end
								`DBG_CMD_NXT_FETCH,
								`DBG_CMD_NXT_FETCH_S: begin
									cpu_wr_out      <= 1'b1;
									cpu_wr_sel_out  <= `DBG_SEL_IDX;
									cpu_wr_data_out <= idx_next;
									mem_addr_out    <= idx_next;
									last_addr       <= idx_next;
								end
								`DBG_CMD_NXT_STORE,
								`DBG_CMD_NXT_STORE_S: begin
									cpu_wr_out      <= 1'b1;
									cpu_wr_sel_out  <= `DBG_SEL_IDX;
									cpu_wr_data_out <= idx_next;
									mem_addr_out    <= idx_next;
									mem_wdata_out   <= shreg[7:0];
									mem_wr_out      <= 1'b1;
								end
								default: begin
									// unknown code: consumed, nothing done
									state     <= ST_IDLE;
									dly_start <= 1'b0;
								end
							endcase
						end
					end
					ST_CAPT: begin
						// read data is valid one cycle after the strobe
						if (rep_n == 2'h1) begin
							rep   <= {rep[23:16], mem_rdata_in, 8'h00};
							rep_n <= 2'h2;
						end else begin
							rep   <= {mem_rdata_in, 16'h0000};
							rep_n <= 2'h1;
						end
						if (dbg_no_delay(cmd))
							state <= ST_SEND;
						else begin
							dly_start <= 1'b1;
							state     <= ST_WAIT;
						end
					end
					ST_WAIT: begin
						// skipped delay falls straight through
						if (dly_done || dbg_no_delay(cmd)) begin
							ack_pulse_out <= ack_en & ~dbg_no_delay(cmd);
							state <= (rep_n == 2'h0) ? ST_IDLE : ST_SEND;
							if (cmd == `DBG_CMD_RESUME || cmd == `DBG_CMD_RESUME_TAG)
								cpu_resume_out <= 1'b1;
							if (cmd == `DBG_CMD_STEP)
								cpu_step_out <= 1'b1;
						end
					end
					ST_SEND: begin
						// one answer byte per cycle, most significant first
						tx_valid_out <= 1'b1;
						tx_byte_out  <= rep[23:16];
						rep          <= {rep[15:0], 8'h00};
						rep_n        <= rep_n - 2'h1;
						if (rep_n == 2'h1)
							state <= ST_IDLE;
					end
					default: state <= ST_IDLE;
				endcase
			end
			// step finished: back into background state; placed last so the
			// set wins over a resume clearing the flag in the same cycle
			if (cpu_step_done_in)
				bgnd <= 1'b1;
		end
	end

endmodule

// ---- dv/dbg_host_model.sv ----
// behavioural debug host: sends byte sequences and gathers the answers
`timescale 1ns/1ns
module dbg_host_model (
	input  wire       clk_in,
	input  wire       tx_valid_in,
	input  wire [7:0] tx_byte_in,
	output reg        rx_valid_out,
	output reg  [7:0] rx_byte_out,
	output reg        sync_req_out
);
	// ==========
	// answer capture
	logic [7:0] answers[$]; // device bytes in arrival order
	initial begin
		rx_valid_out = 1'b0;
		rx_byte_out  = 8'hA5;
		sync_req_out = 1'b0;
	end
	// answers stand one cycle only, so take them at that edge
	always @(posedge clk_in) begin
		if (tx_valid_in) begin
			answers.push_back(tx_byte_in);
		end
	end
	// ==========
	// requests, changed on the falling edge only
	task send(input logic [7:0] seq[$]);
		foreach (seq[i]) begin
			@(negedge clk_in);
			rx_valid_out = 1'b1;
			rx_byte_out  = seq[i];
		end
		@(negedge clk_in);
		rx_valid_out = 1'b0;
		// released line shows the inverse, never the stale byte
		rx_byte_out  = ~rx_byte_out;
	endtask
	// the speed request has no code: a bare one-cycle strobe
	task sync_req;
		@(negedge clk_in);
		sync_req_out = 1'b1;
		@(negedge clk_in);
		sync_req_out = 1'b0;
	endtask
endmodule

// ---- dv/dbg_cmd_decoder_asserts.sv ----
// concurrent checks on the debug command decoder ports
`timescale 1ns/1ns
module dbg_cmd_decoder_chk (
	input wire       clk_in,
	input wire       rst_in,
	input wire       sync_req_in,
	input wire       rx_valid_in,
	input wire [7:0] rx_byte_in,
	input wire       tx_valid_out,
	input wire       sync_pulse_out,
	input wire       busy_out,
	input wire       mem_rd_out,
	input wire       cpu_step_done_in,
	input wire       cpu_wr_out,
	input wire       cpu_resume_out,
	input wire       cpu_step_out,
	input wire       cpu_halt_out,
	input wire       brk_en_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ==========
	// properties
	property p_sync_start;
		sync_req_in |-> ##[1:3] sync_pulse_out;
	endproperty
	property p_rd_answer;
		mem_rd_out |-> ##[1:40] tx_valid_out;
	endproperty
	// no answer in the two cycles after any host byte
	property p_no_early_tx;
		rx_valid_in |=> !tx_valid_out [*2];
	endproperty
	property p_ctrl_write;
		rx_valid_in && rx_byte_in == 8'hC4 && !busy_out
		##1 rx_valid_in && rx_byte_in[5] |-> ##[1:4] brk_en_out;
	endproperty
	property p_resume_run;
		cpu_resume_out |-> !cpu_halt_out;
	endproperty
	property p_step_run;
		cpu_step_out |-> !cpu_halt_out;
	endproperty
	// halt output lags the background flag by one register stage
	property p_step_back;
		cpu_step_done_in |-> ##2 cpu_halt_out;
	endproperty
	// register loads only while halted
	property p_cpu_wr_bgnd;
		cpu_wr_out |-> cpu_halt_out;
	endproperty
	// ==========
	// assertions and covers
	a_sync_start: assert property (p_sync_start) else $error("no sync pulse");
	a_rd_answer: assert property (p_rd_answer) else $error("read unanswered");
	a_no_early_tx: assert property (p_no_early_tx) else $error("early answer");
	a_ctrl_write: assert property (p_ctrl_write) else $error("control lost");
	a_resume_run: assert property (p_resume_run) else $error("resume halted");
	a_step_run: assert property (p_step_run) else $error("step halted");
	a_step_back: assert property (p_step_back) else $error("no rehalt");
	a_cpu_wr_bgnd: assert property (p_cpu_wr_bgnd) else $error("write running");
	c_sync: cover property (sync_pulse_out);
	c_step: cover property (cpu_step_done_in ##2 cpu_halt_out);
	c_resume: cover property (cpu_resume_out);
endmodule
bind dbg_cmd_decoder dbg_cmd_decoder_chk dbg_cmd_decoder_chk_i (
	.clk_in(clk_in), .rst_in(rst_in), .sync_req_in(sync_req_in),
	.rx_valid_in(rx_valid_in), .rx_byte_in(rx_byte_in), .tx_valid_out(tx_valid_out),
	.sync_pulse_out(sync_pulse_out), .busy_out(busy_out), .mem_rd_out(mem_rd_out),
	.cpu_step_done_in(cpu_step_done_in), .cpu_wr_out(cpu_wr_out),
	.cpu_resume_out(cpu_resume_out), .cpu_step_out(cpu_step_out),
	.cpu_halt_out(cpu_halt_out), .brk_en_out(brk_en_out));

// ---- dv/tb.sv ----
// self-checking bench for the debug command decoder
`timescale 1ns/1ns
module tb;
	// ==========
	// signals and bench state
	reg         clk_in, rst_in, cpu_step_done_in;
	reg  [7:0]  acc, flg, last_wd;
	reg  [15:0] pc, idx, sp, last_wa;
	wire        rx_valid, sync_req, tx_valid, sync_pulse, ack, busy, mem_wr;
	wire        cpu_wr, resume, step, halt, brk_en;
	wire [7:0]  rx_byte, tx_byte, wdata, rdata;
	wire [15:0] addr, wr_data, brk_addr;
	wire [2:0]  wr_sel;
	int         failures, tests_run, n_ack, n_res, n_step;
	// memory model: content derived from the address, ready in the same cycle as the address
	function automatic logic [7:0] mem(input logic [15:0] a);
		mem = a[7:0] ^ a[15:8];
	endfunction
	assign rdata = mem(addr);
	dbg_cmd_decoder dbg_cmd_decoder_i (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .sync_req_in(sync_req),
		.rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .tx_valid_out(tx_valid),
		.tx_byte_out(tx_byte), .sync_pulse_out(sync_pulse), .ack_pulse_out(ack),
		.busy_out(busy), .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_rd_out(),
		.mem_wr_out(mem_wr), .mem_rdata_in(rdata), .cpu_acc_in(acc), .cpu_flags_in(flg),
		.cpu_pc_in(pc), .cpu_idx_in(idx), .cpu_sp_in(sp), .cpu_step_done_in(cpu_step_done_in),
		.cpu_wr_out(cpu_wr), .cpu_wr_sel_out(wr_sel), .cpu_wr_data_out(wr_data),
		.cpu_resume_out(resume), .cpu_step_out(step), .cpu_halt_out(halt),
		.brk_addr_out(brk_addr), .brk_en_out(brk_en));
	dbg_host_model dbg_host_model_i (.clk_in(clk_in), .tx_valid_in(tx_valid),
		.tx_byte_in(tx_byte), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte),
		.sync_req_out(sync_req));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// ==========
	// cpu model and strobe counters
	always @(posedge clk_in) begin
		if (ack) n_ack++;
		if (resume) n_res++;
		if (step) n_step++;
		if (rst_in) begin
			acc <= 8'h3C;
			flg <= 8'h81;
			pc <= 16'h1F2E;
			idx <= 16'h0400;
			sp <= 16'h00FF;
			last_wa <= 16'h0000;
			last_wd <= 8'h00;
		end
		if (mem_wr) begin
			last_wa <= addr;
			last_wd <= wdata;
		end
		if (cpu_wr) begin
			case (wr_sel)
				3'h0: acc <= wr_data[7:0];
				3'h1: flg <= wr_data[7:0];
				3'h2: pc <= wr_data;
				3'h3: idx <= wr_data;
				default: sp <= wr_data;
			endcase
		end
	end
	// stepped instruction finishes half a cycle after the strobe, at the next falling edge
	always @(negedge clk_in) cpu_step_done_in <= step;
	// ==========
	// helpers
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] pop();
		pop = dbg_host_model_i.answers.pop_front();
	endfunction
	// send one command, then wait for n answers and an idle sequencer
	task run(input logic [7:0] s[$], input int n);
		int k;
		k = 0;
		dbg_host_model_i.send(s);
		repeat (3) @(negedge clk_in);
		while ((dbg_host_model_i.answers.size() < n || busy) && k < 200) begin
			@(negedge clk_in);
			k++;
		end
		repeat (2) @(negedge clk_in);
		if (k >= 200) failures++;
	endtask
	task complete_run;
		if (failures == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ==========
	// scenarios
	task t_sync;
		int c;
		c = 0;
		dbg_host_model_i.sync_req;
		repeat (300) begin
			@(negedge clk_in);
			if (sync_pulse) c++;
		end
		chk(c, 128);
	endtask
	// running: halt-only command and disallowed halt both ignored
	task t_gate;
		run('{8'h68}, 0);
		chk(dbg_host_model_i.answers.size(), 0);
		run('{8'h90}, 0);
		chk(halt, 1'b0);
		run('{8'hE4}, 1);
		chk(pop(), 8'h00);
		run('{8'hC4, 8'hFF}, 0);
		chk(brk_en, 1'b1);
		run('{8'h90}, 0);
		chk(halt, 1'b1);
		run('{8'hE4}, 1);
		chk(pop(), 8'hE0);
	endtask
	task t_ack;
		int a;
		run('{8'hD5}, 0);
		a = n_ack;
		run('{8'hE0, 8'h12, 8'h34}, 1);
		chk(pop(), mem(16'h1234));
		chk(n_ack - a, 1);
		run('{8'hE4}, 1);
		chk(pop(), 8'hF0);
		run('{8'hD6}, 0);
		a = n_ack;
		run('{8'hE0, 8'h12, 8'h34}, 1);
		chk(pop(), mem(16'h1234));
		chk(n_ack - a, 0);
	endtask
	task t_mem;
		run('{8'hC0, 8'h23, 8'h45, 8'h5A}, 0);
		chk(last_wa, 16'h2345);
		chk(last_wd, 8'h5A);
		run('{8'hC1, 8'h34, 8'h56, 8'hA5}, 1);
		chk(pop(), 8'hE0);
		chk(last_wa, 16'h3456);
		run('{8'hE1, 8'h13, 8'h57}, 2);
		chk(pop(), 8'hE0);
		chk(pop(), mem(16'h1357));
		run('{8'hE8}, 2);
		chk(pop(), 8'hE0);
		chk(pop(), mem(16'h1357));
		run('{8'hC2, 8'hAB, 8'hCD}, 0);
		chk(brk_addr, 16'hABCD);
		run('{8'hE2}, 2);
		chk(pop(), 8'hAB);
		chk(pop(), 8'hCD);
	endtask
	// load each cpu register, then fetch it back through the cpu model
	task t_regs;
		logic [7:0]  ld[5];
		logic [7:0]  fe[5];
		logic [15:0] v;
		ld = '{8'h48, 8'h49, 8'h4B, 8'h4C, 8'h4F};
		fe = '{8'h68, 8'h69, 8'h6B, 8'h6C, 8'h6F};
		for (int i = 0; i < 5; i++) begin
			v = 16'h1111 * 16'(i + 1);
			if (i < 2) begin
				run('{ld[i], v[7:0]}, 0);
				run('{fe[i]}, 1);
				chk(pop(), v[7:0]);
			end else begin
				run('{ld[i], v[15:8], v[7:0]}, 0);
				run('{fe[i]}, 2);
				chk(pop(), v[15:8]);
				chk(pop(), v[7:0]);
			end
		end
	endtask
	task t_next;
		run('{8'h70}, 1);
		chk(pop(), mem(16'h4445));
		run('{8'h71}, 2);
		chk(pop(), 8'hE0);
		chk(pop(), mem(16'h4446));
		run('{8'h50, 8'h77}, 0);
		chk(last_wa, 16'h4447);
		chk(last_wd, 8'h77);
		run('{8'h51, 8'h88}, 1);
		chk(pop(), 8'hE0);
		chk(last_wa, 16'h4448);
	endtask
	task t_run;
		int s;
		s = n_step;
		run('{8'h10}, 0);
		chk(n_step - s, 1);
		chk(halt, 1'b1);
		s = n_res;
		run('{8'h08}, 0);
		chk(n_res - s, 1);
		chk(halt, 1'b0);
		run('{8'h69}, 0);
		chk(dbg_host_model_i.answers.size(), 0);
		run('{8'h90}, 0);
		run('{8'h18}, 0);
		chk(n_res - s, 2);
		chk(halt, 1'b0);
	endtask
	// ==========
	// main sequence and watchdog
	initial begin
		rst_in = 1'b1;
		repeat (4) @(negedge clk_in);
		rst_in = 1'b0;
		t_sync;
		t_gate;
		t_ack;
		t_mem;
		t_regs;
		t_next;
		t_run;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		complete_run;
	end
endmodule
